//--- src/sps_flash_seq.sv
// Self-programming flash sequencer: table pointer, byte latch, 64 holding
// registers, unlock protection and the timed erase and program cycles.
// Assumes an APB master on sys_clk and a flash macro on sys_clk whose read
// data follows flashRdAddr one cycle later and holds while the address holds.
//
// Behaviour
// - One table read loads one byte.
// - Table read may update the pointer.
// - Address bit zero picks high byte.
// - Erase clears block at pointer 20:10.
// - No single-word erase from inside.
// - Erase needs write enable and erase select.
// - Start only right after unlock pair.
// - Row erase stalls the core about 2 ms.
// - Timer ends long cycle; core halted meanwhile.
// - Programming always covers 64 bytes.
// - 64 holding registers loaded by table writes.
// - Table write is short, no stall.
// - Holding registers keep contents after programming.
// - Start bit only set by software, hardware clears.
// - Pointer 5:0 picks holding, 20:6 block.
// - Error flag on reset-cut or improper start.
// - Four pointer modes, low 21 bits only.
`timescale 1ns/1ps
`default_nettype none
`include "sps_defines.svh"
module sps_flash_seq #(
  parameter int ERASE_CYCLES = `SPS_ERASE_CYC,
  parameter int PROG_CYCLES  = `SPS_PROG_CYC
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic         porRst_b,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output var  logic         pready,
  output var  logic [31:0]  prdata,
  output var  logic         pslverr,
  output var  logic         cpuStall,
  output var  logic [20:0]  flashRdAddr,
  input  wire logic [15:0]  flashRdData,
  output var  logic         flashEraseBusy,
  output var  logic [10:0]  eraseBlock,
  output var  logic         flashProgBusy,
  output var  logic [14:0]  progBlock,
  output var  logic [511:0] holdImage
);
  import sps_pkg::*;

  localparam int MAXC = (ERASE_CYCLES > PROG_CYCLES) ? ERASE_CYCLES : PROG_CYCLES;
  localparam int CW   = $clog2(MAXC + 1);

  // Register state.
  logic [21:0]   ptr;
  logic [7:0]    tblLatch;
  logic          wen;
  logic          eraseSel;
  logic          startBit;
  logic          err;
  sps_unlock_t   unlock;
  sps_op_t       op;
  logic          rdPending;
  logic [7:0]    hold [`SPS_HOLD_N];

  logic [21:0]   next_ptr;
  logic [7:0]    next_tblLatch;
  logic          next_wen;
  logic          next_eraseSel;
  logic          next_startBit;
  logic          next_err;
  sps_unlock_t   next_unlock;
  sps_op_t       next_op;
  logic          next_rdPending;
  logic          next_pready;
  logic [31:0]   next_prdata;
  logic          next_pslverr;
  logic [20:0]   next_flashRdAddr;
  logic [10:0]   next_eraseBlock;
  logic [14:0]   next_progBlock;

  // Decode of the current APB access.
  logic          access;
  logic          take;
  logic          wrTake;
  logic          isCtrl;
  logic          isUnlock;
  logic          isPtr;
  logic          isLatch;
  logic          isTcmd;
  logic          mapped;
  logic          tblRdReq;
  logic          tblOp;
  logic          tblWr;
  sps_ptr_mode_t mode;
  logic [20:0]   effLow;
  logic          startReq;
  logic          startOk;
  logic          timerStart;
  logic [CW-1:0] timerLoad;
  logic          timerDone;
  logic          sysRst_b;

  assign sysRst_b = rst_b & porRst_b;
  assign access   = psel & penable;
  assign take     = access & pready;
  assign wrTake   = take & pwrite;
  assign isCtrl   = (paddr == `SPS_OFF_CTRL);
  assign isUnlock = (paddr == `SPS_OFF_UNLOCK);
  assign isPtr    = (paddr == `SPS_OFF_PTR);
  assign isLatch  = (paddr == `SPS_OFF_LATCH);
  assign isTcmd   = (paddr == `SPS_OFF_TCMD);
  assign mapped   = isCtrl | isUnlock | isPtr | isLatch | isTcmd;
  assign mode     = sps_ptr_mode_t'(pwdata[`SPS_B_MODE_LO +: 2]);
  assign tblOp    = wrTake & isTcmd;
  assign tblWr    = tblOp & pwdata[`SPS_B_TWRITE];
  assign tblRdReq = access & pwrite & isTcmd & ~pwdata[`SPS_B_TWRITE];

  // Effective pointer: pre-increment touches only the low 21 bits.
  assign effLow = (mode == SPS_PM_PRE_INC) ? ptr[20:0] + 21'h000001 : ptr[20:0];

  // A start is honoured only straight after the unlock pair and with write
  // enable in the same write; anything else counts as improper.
  assign startReq   = wrTake & isCtrl & pwdata[`SPS_B_START] & ~startBit;
  assign startOk    = startReq & (unlock == SPS_UNL_ARMED) & pwdata[`SPS_B_WEN];
  assign timerStart = startOk;
  assign timerLoad  = pwdata[`SPS_B_ERASE] ? CW'(ERASE_CYCLES) : CW'(PROG_CYCLES);

  // Bus slave: one wait state per access, a second for table reads while the
  // flash word arrives; no access completes while a long cycle runs, which is
  // how the core is held off the flash.
  always_comb begin
    next_pready      = access & ~pready & (op == SPS_OP_IDLE) & ~startBit
                       & (~tblRdReq | rdPending);
    next_rdPending   = tblRdReq & ~pready;
    next_flashRdAddr = flashRdAddr;
    if (tblRdReq & ~pready & ~rdPending) begin
      next_flashRdAddr = {ptr[21], effLow[20:1]};
    end
    next_pslverr = next_pready & ~mapped;
    next_prdata  = prdata;
    if (next_pready) begin
      next_prdata = 32'h00000000;
      if (!pwrite) begin
        unique case (1'b1)
          isCtrl: begin
            next_prdata[`SPS_B_ERASE] = eraseSel;
            next_prdata[`SPS_B_ERR]   = err;
            next_prdata[`SPS_B_WEN]   = wen;
            next_prdata[`SPS_B_START] = startBit;
          end
          isPtr:   next_prdata[21:0] = ptr;
          isLatch: next_prdata[7:0]  = tblLatch;
          default: next_prdata = 32'h00000000; // Unlock, command and unmapped read 0.
        endcase
      end
    end
  end

  // Pointer, latch and unlock tracking.
  always_comb begin
    next_ptr      = ptr;
    next_tblLatch = tblLatch;
    next_unlock   = unlock;
    if (wrTake) begin
      next_unlock = SPS_UNL_IDLE; // Any other write breaks the sequence.
      if (isUnlock) begin
        if (pwdata[7:0] == `SPS_KEY_FIRST) begin
          next_unlock = SPS_UNL_FIRST;
        end else if (pwdata[7:0] == `SPS_KEY_SECOND && unlock == SPS_UNL_FIRST) begin
          next_unlock = SPS_UNL_ARMED;
        end
      end
      if (isPtr) begin
        next_ptr = pwdata[21:0];
      end
      if (isLatch) begin
        next_tblLatch = pwdata[7:0];
      end
    end
    if (tblOp) begin
      // Only the low 21 bits move; bit 21 stays as loaded.
      unique case (mode)
        SPS_PM_NONE:     next_ptr[20:0] = effLow;
        SPS_PM_POST_INC: next_ptr[20:0] = effLow + 21'h000001;
        SPS_PM_POST_DEC: next_ptr[20:0] = effLow - 21'h000001;
        SPS_PM_PRE_INC:  next_ptr[20:0] = effLow;
      endcase
      if (!pwdata[`SPS_B_TWRITE]) begin
        // One byte per read; address bit zero picks the high byte.
        next_tblLatch = effLow[0] ? flashRdData[15:8] : flashRdData[7:0];
      end
    end
  end

  // Control bits and the long-cycle state.
  always_comb begin
    next_wen        = wen;
    next_eraseSel   = eraseSel;
    next_startBit   = startBit;
    next_err        = err;
    next_op         = op;
    next_eraseBlock = eraseBlock;
    next_progBlock  = progBlock;
    if (wrTake & isCtrl) begin
      next_wen      = pwdata[`SPS_B_WEN];
      next_eraseSel = pwdata[`SPS_B_ERASE];
      next_err      = pwdata[`SPS_B_ERR];
    end
    if (startReq & ~startOk) begin
      next_err = 1'b1; // Improper attempt: flag it, start nothing.
    end
    if (startOk) begin
      next_startBit = 1'b1; // Software can only set this bit.
      next_err      = 1'b1; // Stays set unless the timer completes the cycle.
      if (pwdata[`SPS_B_ERASE]) begin
        // Whole 1024-byte block only; the low ten bits are dropped.
        next_op         = SPS_OP_ERASE;
        next_eraseBlock = ptr[20:10];
      end else begin
        // Always the whole 64-byte block.
        next_op        = SPS_OP_PROG;
        next_progBlock = ptr[20:6];
      end
    end
    if (timerDone) begin
      // Short of a reset, the timer alone ends the cycle.
      next_startBit = 1'b0;
      next_err      = 1'b0;
      next_op       = SPS_OP_IDLE;
      if (op == SPS_OP_ERASE) begin
        next_eraseSel = 1'b0;
      end
    end
  end

  // Registers. A warm reset during a long cycle leaves the error flag set;
  // of the two resets, only the power-on reset clears it.
  always_ff @(posedge sys_clk) begin
    if (!porRst_b || !rst_b) begin
      ptr            <= 22'h000000;
      tblLatch       <= 8'h00;
      wen            <= 1'b0;
      eraseSel       <= 1'b0;
      startBit       <= 1'b0;
      err            <= porRst_b & (err | (op != SPS_OP_IDLE));
      unlock         <= SPS_UNL_IDLE;
      op             <= SPS_OP_IDLE;
      rdPending      <= 1'b0;
      pready         <= 1'b0;
      prdata         <= 32'h00000000;
      pslverr        <= 1'b0;
      cpuStall       <= 1'b0;
      flashRdAddr    <= 21'h000000;
      flashEraseBusy <= 1'b0;
      flashProgBusy  <= 1'b0;
      eraseBlock     <= 11'h000;
      progBlock      <= 15'h0000;
    end else begin
      ptr            <= next_ptr;
      tblLatch       <= next_tblLatch;
      wen            <= next_wen;
      eraseSel       <= next_eraseSel;
      startBit       <= next_startBit;
      err            <= next_err;
      unlock         <= next_unlock;
      op             <= next_op;
      rdPending      <= next_rdPending;
      pready         <= next_pready;
      prdata         <= next_prdata;
      pslverr        <= next_pslverr;
      cpuStall       <= (next_op != SPS_OP_IDLE);
      flashRdAddr    <= next_flashRdAddr;
      flashEraseBusy <= (next_op == SPS_OP_ERASE);
      flashProgBusy  <= (next_op == SPS_OP_PROG);
      eraseBlock     <= next_eraseBlock;
      progBlock      <= next_progBlock;
    end
  end

  // Holding registers: a table write only updates one entry, chosen by
  // pointer bits 5:0. They are never cleared by programming, so software
  // must refill them.
  genvar gi;
  generate
    for (gi = 0; gi < `SPS_HOLD_N; gi++) begin : g_hold
      logic [7:0] next_hold;
      assign next_hold = (tblWr && effLow[5:0] == 6'(gi)) ? tblLatch : hold[gi];
      always_ff @(posedge sys_clk) begin
        if (!porRst_b) begin
          hold[gi] <= 8'h00;
        end else begin
          hold[gi] <= next_hold;
        end
      end
      assign holdImage[8*gi +: 8] = hold[gi];
    end
  endgenerate

  sps_prog_timer #(
    .CW (CW)
  ) uTimer (
    .sys_clk (sys_clk),
    .rst_b   (sysRst_b),
    .start   (timerStart),
    .loadVal (timerLoad),
    .done    (timerDone)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b || !porRst_b);

  property p_start_unlocked;
    $rose(cpuStall) |-> $past(unlock == SPS_UNL_ARMED && pwdata[`SPS_B_WEN]);
  endproperty
  a_start_unlocked: assert property (p_start_unlocked) else $error("Start without unlock.");

  property p_improper;
    startReq && !startOk |=> err && !cpuStall && !startBit;
  endproperty
  a_improper: assert property (p_improper) else $error("Improper start not refused.");

  property p_stall_holds;
    cpuStall && !timerDone |=> cpuStall && !pready;
  endproperty
  a_stall_holds: assert property (p_stall_holds) else $error("Stall dropped early.");

  property p_done_clears;
    timerDone |=> !startBit && !cpuStall && !err;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("Completion left bits set.");

  property p_erase_block;
    $rose(flashEraseBusy) |-> eraseBlock == $past(ptr[20:10]) && $past(pwdata[`SPS_B_ERASE]);
  endproperty
  a_erase_block: assert property (p_erase_block) else $error("Wrong erase block.");

  property p_prog_block;
    $rose(flashProgBusy) |-> progBlock == $past(ptr[20:6]);
  endproperty
  a_prog_block: assert property (p_prog_block) else $error("Wrong program block.");

  property p_tbl_write_short;
    tblWr |=> !cpuStall ##1 pready || !access;
  endproperty
  a_tbl_write_short: assert property (p_tbl_write_short) else $error("Table write stalled.");

  property p_read_byte;
    tblOp && !pwdata[`SPS_B_TWRITE] |=>
      tblLatch == ($past(effLow[0]) ? $past(flashRdData[15:8]) : $past(flashRdData[7:0]));
  endproperty
  a_read_byte: assert property (p_read_byte) else $error("Wrong byte latched.");

  property p_post_inc;
    tblOp && mode == SPS_PM_POST_INC |=>
      ptr[20:0] == $past(ptr[20:0]) + 21'h000001 && ptr[21] == $past(ptr[21]);
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("Pointer not advanced.");

  property p_hold_kept;
    timerDone |=> holdImage == $past(holdImage);
  endproperty
  a_hold_kept: assert property (p_hold_kept) else $error("Holding registers lost.");

  c_erase:    cover property ($rose(flashEraseBusy));
  c_prog:     cover property ($rose(flashProgBusy));
  c_read:     cover property (tblOp && !pwdata[`SPS_B_TWRITE]);
  c_improper: cover property (startReq && !startOk);

endmodule : sps_flash_seq
`default_nettype wire

//--- src/sps_defines.svh
// Constants for the self-programming flash sequencer: register offsets, bit
// positions, unlock keys and programming times.
// Assumes a 40 MHz sys_clk and a 32-bit APB register bus.
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

// Register byte offsets on the APB bus.
`define SPS_OFF_CTRL     8'h00
`define SPS_OFF_UNLOCK   8'h04
`define SPS_OFF_PTR      8'h08
`define SPS_OFF_LATCH    8'h0C
`define SPS_OFF_TCMD     8'h10

// Memory control register bit positions.
`define SPS_B_ERASE      4
`define SPS_B_ERR        3
`define SPS_B_WEN        2
`define SPS_B_START      1

// Table command register fields: bit 0 selects write, bits 2:1 the pointer mode.
`define SPS_B_TWRITE     0
`define SPS_B_MODE_LO    1

// Unlock keys, written in this order.
`define SPS_KEY_FIRST    8'h55
`define SPS_KEY_SECOND   8'hAA

// Sizes.
`define SPS_PTR_W        22
`define SPS_HOLD_N       64

// Timing: times in microseconds, counts derived from the clock rate.
`define SPS_CLK_MHZ      40
`define SPS_ERASE_US     2000
`define SPS_PROG_US      2000
`define SPS_ERASE_CYC    (`SPS_ERASE_US * `SPS_CLK_MHZ)
`define SPS_PROG_CYC     (`SPS_PROG_US * `SPS_CLK_MHZ)

`endif

//--- src/sps_pkg.sv
// Types shared by the flash sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package sps_pkg;

  // Pointer update applied by a table instruction.
  typedef enum logic [1:0] {
    SPS_PM_NONE     = 2'b00,
    SPS_PM_POST_INC = 2'b01,
    SPS_PM_POST_DEC = 2'b10,
    SPS_PM_PRE_INC  = 2'b11
  } sps_ptr_mode_t;

  // Long operation in progress.
  typedef enum logic [1:0] {
    SPS_OP_IDLE  = 2'b00,
    SPS_OP_ERASE = 2'b01,
    SPS_OP_PROG  = 2'b10
  } sps_op_t;

  // Progress through the two-write unlock sequence.
  typedef enum logic [1:0] {
    SPS_UNL_IDLE  = 2'b00,
    SPS_UNL_FIRST = 2'b01,
    SPS_UNL_ARMED = 2'b10
  } sps_unlock_t;

endpackage : sps_pkg

//--- src/sps_prog_timer.sv
// Internal programming timer: counts down a loaded cycle count and pulses done.
// Assumes start is a one-cycle pulse on sys_clk and is not given while counting.
`timescale 1ns/1ps
`default_nettype none
module sps_prog_timer #(
  parameter int CW = 17
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_b,
  input  wire logic          start,
  input  wire logic [CW-1:0] loadVal,
  output var  logic          done
);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_done;

  // Down counter; done fires on the edge after the count reaches one.
  always_comb begin
    next_cnt  = cnt;
    next_done = 1'b0;
    if (start) begin
      next_cnt = loadVal;
    end else if (cnt != '0) begin
      next_cnt  = cnt - 1'b1;
      next_done = (cnt == CW'(1));
    end
  end

  // A reset mid-count simply abandons the cycle.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt  <= '0;
      done <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      done <= next_done;
    end
  end

endmodule : sps_prog_timer
`default_nettype wire

//--- dv/sps_flash_model.sv
// Flash array stand-in for the sequencer's read port.
// Assumes the sequencer holds flashRdAddr until it has used the word.
`timescale 1ns/1ps
`default_nettype none
module sps_flash_model (
  input  wire logic        sys_clk,
  input  wire logic [20:0] rdAddr,
  output var  logic [15:0] rdData
);
  // Each 16-bit word is a pattern of its own word address, one cycle late like the macro.
  // The two bytes differ for every address the test reads, so a swapped byte select shows at once.
  always_ff @(posedge sys_clk) begin
    rdData <= {rdAddr[7:0] ^ 8'h5A, rdAddr[15:8] ^ rdAddr[7:0] ^ {3'h0, rdAddr[20:16]}};
  end
endmodule : sps_flash_model
`default_nettype wire

//--- dv/self_program_flash_sequencer_tb_top.sv
// Testbench for the flash sequencer: APB tasks and directed sequences.
// Assumes the sequencer's defines header and package are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sps_defines.svh"
module self_program_flash_sequencer_tb_top;
  import sps_pkg::*;
  localparam int EC = 30;
  localparam int PC = 20;
  logic          sys_clk, rst_b, porRst_b, psel, penable, pwrite, pready, pslverr, cpuStall;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rdv;
  logic [20:0]   flashRdAddr;
  logic [15:0]   flashRdData, w;
  logic          flashEraseBusy, flashProgBusy, errv;
  logic [10:0]   eraseBlock, eraseSeen;
  logic [14:0]   progBlock, progSeen;
  logic [511:0]  holdImage;
  logic [21:0]   p, e, np;
  int            n_fail = 0;
  int            n_tests = 0;
  int            stallCnt = 0;
  logic [21:0]   ps [5] = '{22'h000101, 22'h000101, 22'h000100, 22'h3FFFFF, 22'h3FFFFF};
  sps_ptr_mode_t ms [5] = '{SPS_PM_NONE, SPS_PM_POST_INC, SPS_PM_POST_DEC, SPS_PM_PRE_INC,
                            SPS_PM_POST_INC};

  sps_flash_seq #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC)) u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .porRst_b(porRst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .cpuStall(cpuStall), .flashRdAddr(flashRdAddr),
    .flashRdData(flashRdData), .flashEraseBusy(flashEraseBusy), .eraseBlock(eraseBlock),
    .flashProgBusy(flashProgBusy), .progBlock(progBlock), .holdImage(holdImage));

  sps_flash_model u_flash (.sys_clk(sys_clk), .rdAddr(flashRdAddr), .rdData(flashRdData));

  // Free-running 40 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Counts stalled cycles and remembers which blocks the long cycles aimed at.
  always @(posedge sys_clk) begin
    if (cpuStall === 1'b1) stallCnt <= stallCnt + 1;
    if (flashEraseBusy === 1'b1) eraseSeen <= eraseBlock;
    if (flashProgBusy === 1'b1) progSeen <= progBlock;
  end

  function automatic logic [15:0] fw(input logic [20:0] a);
    return {a[7:0] ^ 8'h5A, a[15:8] ^ a[7:0] ^ {3'h0, a[20:16]}};
  endfunction : fw

  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // One APB transfer; the request holds until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 3000);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) chk(0, 1, "no answer");
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp, m);
  endtask : rc

  // Full software start order: set bits, two unlock keys, then the start write.
  task automatic go(input logic [31:0] c);
    stallCnt = 0;
    wr(`SPS_OFF_CTRL, c & 32'hFFFFFFFD);
    wr(`SPS_OFF_UNLOCK, 32'(`SPS_KEY_FIRST));
    wr(`SPS_OFF_UNLOCK, 32'(`SPS_KEY_SECOND));
    wr(`SPS_OFF_CTRL, c);
  endtask : go

  // A refused start must flag an error and never stall; the flag is cleared afterwards.
  // The write-enable and erase bits written with the refused start stay readable next to the error flag.
  task automatic refused(input logic [31:0] exp, input string m);
    rc(`SPS_OFF_CTRL, exp, m);
    chk(rdv & 32'h8, 32'h8, m);
    chk(32'(stallCnt), 0, m);
    wr(`SPS_OFF_CTRL, 32'h0);
    $display("test %s done", m);
  endtask : refused

  // Main sequence.
  initial begin
    {rst_b, porRst_b, psel, penable, pwrite} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    porRst_b <= 1'b1;
    rc(`SPS_OFF_CTRL, 32'h0, "ctrl reset");
    rc(`SPS_OFF_UNLOCK, 32'h0, "unlock reads zero");
    rc(`SPS_OFF_PTR, 32'h0, "pointer reset");
    rc(8'h20, 32'h0, "unmapped read");
    chk(32'(errv), 1, "unmapped error");
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      p = ps[i];
      e = (ms[i] == SPS_PM_PRE_INC) ? {p[21], p[20:0] + 21'h1} : p;
      case (ms[i])
        SPS_PM_POST_INC: np = {p[21], p[20:0] + 21'h1};
        SPS_PM_POST_DEC: np = {p[21], p[20:0] - 21'h1};
        default:         np = e;
      endcase
      w = fw({e[21], e[20:1]});
      wr(`SPS_OFF_PTR, 32'(p));
      wr(`SPS_OFF_TCMD, {29'h0, ms[i], 1'b0});
      rc(`SPS_OFF_LATCH, 32'(e[0] ? w[15:8] : w[7:0]), "latch");
      rc(`SPS_OFF_PTR, 32'(np), "pointer update");
    end
    $display("test table read done");
    stallCnt = 0;
    wr(`SPS_OFF_PTR, 32'h0155C0);
    for (int i = 0; i < 64; i++) begin
      wr(`SPS_OFF_LATCH, 32'(i ^ 8'h3C));
      wr(`SPS_OFF_TCMD, {29'h0, SPS_PM_POST_INC, 1'b1});
    end
    chk(32'(stallCnt), 0, "table write stall");
    rc(`SPS_OFF_PTR, 32'h015600, "pointer after fill");
    for (int i = 0; i < 64; i++) chk(32'(holdImage[8*i+:8]), 32'(i ^ 8'h3C), "hold");
    $display("test table write done");
    wr(`SPS_OFF_PTR, 32'h0155C0);
    go(32'h6);
    rc(`SPS_OFF_CTRL, 32'h4, "ctrl after program");
    chk(32'(stallCnt >= PC && stallCnt <= PC + 2), 1, "program stall");
    chk(32'(progSeen), 32'h557, "program block");
    chk(32'(holdImage[47:40]), 32'h39, "hold kept");
    $display("test program done");
    wr(`SPS_OFF_PTR, 32'h012345);
    go(32'h16);
    rc(`SPS_OFF_CTRL, 32'h4, "ctrl after erase");
    chk(32'(stallCnt >= EC && stallCnt <= EC + 2), 1, "erase stall");
    chk(32'(eraseSeen), 32'h048, "erase block");
    $display("test erase done");
    stallCnt = 0;
    wr(`SPS_OFF_CTRL, 32'h6);
    refused(32'hC, "start without unlock");
    go(32'h12);
    refused(32'h18, "start without write enable");
    go(32'h4);
    wr(`SPS_OFF_UNLOCK, 32'(`SPS_KEY_FIRST));
    wr(`SPS_OFF_UNLOCK, 32'(`SPS_KEY_SECOND));
    wr(`SPS_OFF_PTR, 32'h012345);
    wr(`SPS_OFF_CTRL, 32'h16);
    refused(32'h1C, "broken unlock");
    go(32'h16);
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rc(`SPS_OFF_CTRL, 32'h8, "ctrl after warm reset");
    chk(rdv & 32'h8, 32'h8, "error after cut cycle");
    chk(32'(cpuStall), 0, "stall after warm reset");
    chk(32'(holdImage[47:40]), 32'h39, "hold kept on warm reset");
    porRst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    porRst_b <= 1'b1;
    rc(`SPS_OFF_CTRL, 32'h0, "ctrl after power-on reset");
    chk(32'(holdImage[47:40]), 32'h0, "hold cleared");
    $display("test resets done");
    print_verdict();
  end

  // Watchdog sized well above the fewer than 1000 cycles that the sequence needs.
  initial begin
    #(25 * 20000);
    chk(0, 1, "watchdog");
    print_verdict();
  end
endmodule : self_program_flash_sequencer_tb_top
`default_nettype wire
